// ===== rtl/lscr_pkg.sv
// Purpose: constants for the link serializer configuration registers
// Assumes: byte-wide register port, 5-bit register index
// Notes: strap-derived defaults are assembled in the register module
package lscr_pkg;
	localparam logic [4:0] ADDR_LOCAL_ADDR_LOCK = 5'h00;
	localparam logic [4:0] ADDR_REMOTE_ADDR = 5'h01;
	localparam logic [4:0] ADDR_SPREAD_AUDIO_RATE = 5'h02;
	localparam logic [4:0] ADDR_SPREAD_CAL = 5'h03;
	localparam logic [4:0] ADDR_LOCK_LAST = 5'h1F;
	localparam int LOCK_BIT = 0;
	localparam logic [1:0] SPREAD_DEFAULT_HI = 2'h0;
	localparam logic [2:0] SPREAD_NONE = 3'h0;
	localparam logic [2:0] SPREAD_HALF = 3'h1;
	localparam logic [2:0] SPREAD_ONE_HALF = 3'h2;
	localparam logic [2:0] SPREAD_TWO = 3'h3;
	localparam logic [2:0] SPREAD_NONE_ALT = 3'h4;
	localparam logic [2:0] SPREAD_ONE = 3'h5;
	localparam logic [2:0] SPREAD_THREE = 3'h6;
	localparam logic [2:0] SPREAD_FOUR = 3'h7;
	// Spread depth in tenths of a percent
	localparam logic [5:0] DEPTH_0 = 6'h00;
	localparam logic [5:0] DEPTH_05 = 6'h05;
	localparam logic [5:0] DEPTH_10 = 6'h0A;
	localparam logic [5:0] DEPTH_15 = 6'h0F;
	localparam logic [5:0] DEPTH_20 = 6'h14;
	localparam logic [5:0] DEPTH_30 = 6'h1E;
	localparam logic [5:0] DEPTH_40 = 6'h28;
	localparam logic AUDIO_ON_RESET = 1'b1;
	localparam logic [1:0] RANGE_AUTO = 2'h3;
	localparam logic [1:0] RECAL_ONCE = 2'h0;
	localparam logic [1:0] RECAL_2MS = 2'h1;
	localparam logic [1:0] RECAL_16MS = 2'h2;
	localparam logic [1:0] RECAL_256MS = 2'h3;
	localparam logic [5:0] SAWTOOTH_AUTO = 6'h00;
	localparam logic [7:0] CAL_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : lscr_pkg

// ===== rtl/lscr_regs.sv
// Purpose: first four configuration registers of a video link serializer
// Assumes: control channel supplies a one-cycle write or read strobe
// Notes: straps are synchronised and caught on the third cycle after reset
//
// Behaviour
// - Own bus address in local_address_and_lock bits 7:1, strapped
// - Peer address in remote_address 7:1, bit0 zero
// - Write lock makes local_address_and_lock to 0x1F read-only
// - Decode three-bit spread select into depth
// - Spread select powers up 000 or 001
// - Audio channel enable bit, resets to one
// - Pixel clock range field, resets to auto
// - Serial rate range field, resets to auto
// - Recalibration interval after lock, resets once-only
// - Sawtooth divider zero means automatic calibration
`timescale 1ns/1ps
module lscr_regs (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [6:0] i_own_addr_strap,
	input wire logic [6:0] i_peer_addr_strap,
	input wire logic [1:0] i_config_strap_pins,
	input wire logic [4:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [6:0] o_own_bus_address,
	output logic [6:0] o_peer_bus_address,
	output logic o_config_write_lock,
	output logic [5:0] o_spread_depth,
	output logic o_audio_channel_on,
	output logic [1:0] o_pixel_clock_range,
	output logic o_pixel_clock_auto,
	output logic [1:0] o_serial_rate_range,
	output logic o_serial_rate_auto,
	output logic [1:0] o_spread_recal_interval,
	output logic [5:0] o_sawtooth_divider,
	output logic o_sawtooth_auto
);
	typedef enum logic [1:0] {
		LSCR_ST_STRAP = 2'b01,
		LSCR_ST_RUN = 2'b10
	} lscr_state_t;

	lscr_state_t state_r;
	logic [6:0] own_s1_r, own_s2_r, peer_s1_r, peer_s2_r;
	logic [1:0] conf_s1_r, conf_s2_r;
	logic [7:0] reg0_r, reg1_r, reg2_r, reg3_r;
	logic wr_ok;
	logic [5:0] depth_nxt;

	// Straps are pins: two flops before use
	always_ff @(posedge i_core_clk) begin
		own_s1_r <= i_own_addr_strap;
		own_s2_r <= own_s1_r;
		peer_s1_r <= i_peer_addr_strap;
		peer_s2_r <= peer_s1_r;
		conf_s1_r <= i_config_strap_pins;
		conf_s2_r <= conf_s1_r;
	end

	// Two cycles for synchronisers to fill, then one strap load
	logic [1:0] strap_wait_r;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_r <= LSCR_ST_STRAP;
			strap_wait_r <= 2'h0;
		end else begin
			case (state_r)
				LSCR_ST_STRAP: begin
					strap_wait_r <= strap_wait_r + 2'h1;
					if (strap_wait_r == 2'h2) begin
						state_r <= LSCR_ST_RUN;
					end
				end
				default: begin
					state_r <= LSCR_ST_RUN;
				end
			endcase
		end
	end

	logic strap_load;
	assign strap_load = (state_r == LSCR_ST_STRAP) && (strap_wait_r == 2'h2);

	localparam int LOCK_BIT_W = lscr_pkg::LOCK_BIT;

	// Writes only when running and outside the locked window
	assign wr_ok = i_reg_write && (state_r == LSCR_ST_RUN) &&
		!(reg0_r[LOCK_BIT_W] && i_reg_addr <= lscr_pkg::ADDR_LOCK_LAST);

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			reg0_r <= 8'h00;
			reg1_r <= 8'h00;
		end else if (strap_load) begin
			reg0_r <= {own_s2_r, 1'b0};
			reg1_r <= {peer_s2_r, 1'b0};
		end else if (wr_ok) begin
			if (i_reg_addr == lscr_pkg::ADDR_LOCAL_ADDR_LOCK) begin
				reg0_r <= i_reg_wdata;
			end else if (i_reg_addr == lscr_pkg::ADDR_REMOTE_ADDR) begin
				reg1_r <= {i_reg_wdata[7:1], 1'b0};
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			reg2_r <= {lscr_pkg::SPREAD_NONE, lscr_pkg::AUDIO_ON_RESET,
				lscr_pkg::RANGE_AUTO, lscr_pkg::RANGE_AUTO};
			reg3_r <= lscr_pkg::CAL_RESET;
		end else if (strap_load) begin
			// Only strap 00 selects the half-percent spread
			reg2_r[7:5] <= (conf_s2_r == lscr_pkg::SPREAD_DEFAULT_HI) ?
				lscr_pkg::SPREAD_HALF : lscr_pkg::SPREAD_NONE;
		end else if (wr_ok) begin
			if (i_reg_addr == lscr_pkg::ADDR_SPREAD_AUDIO_RATE) begin
				reg2_r <= i_reg_wdata;
			end else if (i_reg_addr == lscr_pkg::ADDR_SPREAD_CAL) begin
				reg3_r <= i_reg_wdata;
			end
		end
	end

	// Reads always allowed, lock or not
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_read;
			if (!i_reg_read) begin
				o_reg_rdata <= o_reg_rdata;
			end else if (i_reg_addr == lscr_pkg::ADDR_LOCAL_ADDR_LOCK) begin
				o_reg_rdata <= reg0_r;
			end else if (i_reg_addr == lscr_pkg::ADDR_REMOTE_ADDR) begin
				o_reg_rdata <= reg1_r;
			end else if (i_reg_addr == lscr_pkg::ADDR_SPREAD_AUDIO_RATE) begin
				o_reg_rdata <= reg2_r;
			end else if (i_reg_addr == lscr_pkg::ADDR_SPREAD_CAL) begin
				o_reg_rdata <= reg3_r;
			end else begin
				o_reg_rdata <= lscr_pkg::UNMAPPED_READ;
			end
		end
	end

	always_comb begin
		case (reg2_r[7:5])
			lscr_pkg::SPREAD_HALF: depth_nxt = lscr_pkg::DEPTH_05;
			lscr_pkg::SPREAD_ONE_HALF: depth_nxt = lscr_pkg::DEPTH_15;
			lscr_pkg::SPREAD_TWO: depth_nxt = lscr_pkg::DEPTH_20;
			lscr_pkg::SPREAD_ONE: depth_nxt = lscr_pkg::DEPTH_10;
			lscr_pkg::SPREAD_THREE: depth_nxt = lscr_pkg::DEPTH_30;
			lscr_pkg::SPREAD_FOUR: depth_nxt = lscr_pkg::DEPTH_40;
			default: depth_nxt = lscr_pkg::DEPTH_0;
		endcase
	end

	// Decoded controls registered so every output is a flop
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_own_bus_address <= 7'h00;
			o_peer_bus_address <= 7'h00;
			o_config_write_lock <= 1'b0;
			o_spread_depth <= lscr_pkg::DEPTH_0;
			o_audio_channel_on <= lscr_pkg::AUDIO_ON_RESET;
			o_pixel_clock_range <= lscr_pkg::RANGE_AUTO;
			o_pixel_clock_auto <= 1'b1;
			o_serial_rate_range <= lscr_pkg::RANGE_AUTO;
			o_serial_rate_auto <= 1'b1;
			o_spread_recal_interval <= lscr_pkg::RECAL_ONCE;
			o_sawtooth_divider <= lscr_pkg::SAWTOOTH_AUTO;
			o_sawtooth_auto <= 1'b1;
		end else begin
			o_own_bus_address <= reg0_r[7:1];
			o_peer_bus_address <= reg1_r[7:1];
			o_config_write_lock <= reg0_r[LOCK_BIT_W];
			o_spread_depth <= depth_nxt;
			o_audio_channel_on <= reg2_r[4];
			o_pixel_clock_range <= reg2_r[3:2];
			o_pixel_clock_auto <= reg2_r[3:2] == lscr_pkg::RANGE_AUTO;
			o_serial_rate_range <= reg2_r[1:0];
			o_serial_rate_auto <= reg2_r[1:0] == lscr_pkg::RANGE_AUTO;
			o_spread_recal_interval <= reg3_r[7:6];
			o_sawtooth_divider <= reg3_r[5:0];
			o_sawtooth_auto <= reg3_r[5:0] == lscr_pkg::SAWTOOTH_AUTO;
		end
	end

	AST_LOCKED_WRITE_HELD: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		(i_reg_write && reg0_r[0] && state_r == LSCR_ST_RUN)
		|=> $stable(reg0_r) && $stable(reg1_r) && $stable(reg2_r)
		&& $stable(reg3_r))
		else $error("locked write changed a register");
	AST_UNLOCKED_WRITE_LANDS: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		(i_reg_write && !reg0_r[0] && state_r == LSCR_ST_RUN
		&& i_reg_addr == 5'h03) |=> reg3_r == $past(i_reg_wdata))
		else $error("unlocked write lost");
	AST_PEER_BIT0_ZERO: assert property (@(posedge i_core_clk)
		disable iff (i_reset) reg1_r[0] == 1'b0)
		else $error("reserved bit set");
	AST_SPREAD_STRAP: assert property (@(posedge i_core_clk)
		disable iff (i_reset) strap_load |=> reg2_r[7:6] == 2'h0)
		else $error("spread strap default wrong");
	AST_OWN_STRAP: assert property (@(posedge i_core_clk)
		disable iff (i_reset) strap_load |=> reg0_r[7:1] == $past(own_s2_r))
		else $error("own address not strapped");
	AST_SPREAD_DECODE: assert property (@(posedge i_core_clk)
		disable iff (i_reset) (reg2_r[7:5] == 3'h7)[*2] |-> o_spread_depth == 6'h28)
		else $error("spread decode wrong");
	AST_AUDIO_FOLLOWS: assert property (@(posedge i_core_clk)
		disable iff (i_reset) ##1 o_audio_channel_on == $past(reg2_r[4]))
		else $error("audio enable not followed");
	AST_PIX_AUTO: assert property (@(posedge i_core_clk)
		disable iff (i_reset) ##1 o_pixel_clock_auto == ($past(reg2_r[3:2]) == 2'h3))
		else $error("pixel auto wrong");
	AST_SER_AUTO: assert property (@(posedge i_core_clk)
		disable iff (i_reset) ##1 o_serial_rate_auto == ($past(reg2_r[1:0]) == 2'h3))
		else $error("serial auto wrong");
	AST_RECAL: assert property (@(posedge i_core_clk)
		disable iff (i_reset) ##1 o_spread_recal_interval == $past(reg3_r[7:6]))
		else $error("recal interval wrong");
	AST_SAW_AUTO: assert property (@(posedge i_core_clk)
		disable iff (i_reset) ##1 o_sawtooth_auto == ($past(reg3_r[5:0]) == 6'h00))
		else $error("sawtooth auto wrong");
	COV_LOCK_SET: cover property (@(posedge i_core_clk) $rose(reg0_r[0]));
	COV_LOCKED_WRITE: cover property (@(posedge i_core_clk)
		i_reg_write && reg0_r[0]);
	COV_READ: cover property (@(posedge i_core_clk) o_reg_rvalid);
endmodule : lscr_regs

// ===== tb/lscr_regs_test.sv
// Purpose: self-checking bench for the configuration registers
// Assumes: straps set at time zero and changed only under reset; inputs move on falling edges
// Notes: lock is entered last, since only reset can clear it
`timescale 1ns/1ps
module lscr_regs_test;
	logic i_core_clk, i_reset, i_reg_write, i_reg_read;
	logic [6:0] i_own_addr_strap, i_peer_addr_strap;
	logic [1:0] i_config_strap_pins;
	logic [4:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata;
	logic o_reg_rvalid, o_config_write_lock, o_audio_channel_on;
	logic o_pixel_clock_auto, o_serial_rate_auto, o_sawtooth_auto;
	logic [6:0] o_own_bus_address, o_peer_bus_address;
	logic [5:0] o_spread_depth, o_sawtooth_divider;
	logic [1:0] o_pixel_clock_range, o_serial_rate_range;
	logic [1:0] o_spread_recal_interval;
	int err_total, samples_checked;
	localparam logic [5:0] DEP [8] = '{lscr_pkg::DEPTH_0,
		lscr_pkg::DEPTH_05, lscr_pkg::DEPTH_15, lscr_pkg::DEPTH_20,
		lscr_pkg::DEPTH_0, lscr_pkg::DEPTH_10, lscr_pkg::DEPTH_30,
		lscr_pkg::DEPTH_40};

	lscr_regs i_dut (.i_core_clk, .i_reset, .i_own_addr_strap,
		.i_peer_addr_strap, .i_config_strap_pins, .i_reg_addr,
		.i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
		.o_reg_rvalid, .o_own_bus_address, .o_peer_bus_address,
		.o_config_write_lock, .o_spread_depth, .o_audio_channel_on,
		.o_pixel_clock_range, .o_pixel_clock_auto, .o_serial_rate_range,
		.o_serial_rate_auto, .o_spread_recal_interval,
		.o_sawtooth_divider, .o_sawtooth_auto);

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	task results;
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk

	task wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_write = 1'b1;
		@(negedge i_core_clk);
		i_reg_write = 1'b0;
		// Decoded outputs trail the register by one edge
		@(negedge i_core_clk);
	endtask : wr_reg

	task rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_read = 1'b1;
		@(negedge i_core_clk);
		i_reg_read = 1'b0;
		chk("rvalid", 8'h01, {7'h00, o_reg_rvalid});
		chk("rdata", exp, o_reg_rdata);
	endtask : rd_chk

	task t_reset;
		rd_chk(5'h00, {7'h52, 1'b0});
		rd_chk(5'h01, {7'h2B, 1'b0});
		rd_chk(5'h02, 8'h3F);
		rd_chk(5'h03, 8'h00);
		chk("lock", 8'h00, {7'h00, o_config_write_lock});
		chk("depth", 8'h05, {2'h0, o_spread_depth});
		chk("audio", 8'h01, {7'h00, o_audio_channel_on});
		chk("pauto", 8'h01, {7'h00, o_pixel_clock_auto});
		chk("sauto", 8'h01, {7'h00, o_serial_rate_auto});
		chk("sdauto", 8'h01, {7'h00, o_sawtooth_auto});
	endtask : t_reset

	task t_spread;
		for (int i = 0; i < 8; i++) begin
			wr_reg(5'h02, {i[2:0], i[0], i[1:0], ~i[1:0]});
			chk("depth", {2'h0, DEP[i]}, {2'h0, o_spread_depth});
			chk("audio", {7'h00, i[0]}, {7'h00, o_audio_channel_on});
			chk("pauto", {7'h00, i[1:0] == 2'h3},
				{7'h00, o_pixel_clock_auto});
			chk("sauto", {7'h00, i[1:0] == 2'h0},
				{7'h00, o_serial_rate_auto});
			if (i[1:0] != 2'h3)
				chk("pixel_clock_range", {6'h00, i[1:0]}, {6'h00, o_pixel_clock_range});
			if (i[1:0] != 2'h0)
				chk("serial_rate_range", {6'h00, ~i[1:0]}, {6'h00, o_serial_rate_range});
		end
	endtask : t_spread

	task t_cal;
		for (int i = 0; i < 4; i++) begin
			wr_reg(5'h03, {i[1:0], i[1:0], 4'h5 & {4{i != 0}}});
			chk("recal", {6'h00, i[1:0]}, {6'h00, o_spread_recal_interval});
			chk("sdauto", {7'h00, i == 0}, {7'h00, o_sawtooth_auto});
			if (i != 0)
				chk("sawtooth_divider", {2'h0, i[1:0], 4'h5}, {2'h0, o_sawtooth_divider});
		end
		wr_reg(5'h01, 8'hFF);
		rd_chk(5'h01, 8'hFE);
		chk("peer", 8'h7F, {1'b0, o_peer_bus_address});
		wr_reg(5'h05, 8'hAA);
		rd_chk(5'h05, 8'h00);
	endtask : t_cal

	task t_lock;
		wr_reg(5'h00, 8'h23);
		chk("lock", 8'h01, {7'h00, o_config_write_lock});
		chk("own", 8'h11, {1'b0, o_own_bus_address});
		// Two write attempts against the lock, three cycles apart
		wr_reg(5'h02, 8'h00);
		wr_reg(5'h00, 8'h00);
		rd_chk(5'h02, 8'hFC);
		rd_chk(5'h00, 8'h23);
		chk("depth", {2'h0, DEP[7]}, {2'h0, o_spread_depth});
		chk("lock", 8'h01, {7'h00, o_config_write_lock});
	endtask : t_lock

	// Mid-run reset with other straps; also clears the lock
	task t_restrap;
		@(negedge i_core_clk);
		i_reset = 1'b1;
		i_own_addr_strap = 7'h35;
		i_config_strap_pins = 2'h1;
		repeat (2) @(negedge i_core_clk);
		i_reset = 1'b0;
		// Lands in the strap period, so it must be dropped
		wr_reg(5'h03, 8'h55);
		rd_chk(5'h03, 8'h00);
		rd_chk(5'h00, {7'h35, 1'b0});
		rd_chk(5'h02, 8'h1F);
		chk("lock", 8'h00, {7'h00, o_config_write_lock});
		chk("own", 8'h35, {1'b0, o_own_bus_address});
		chk("depth", 8'h00, {2'h0, o_spread_depth});
		chk("sdauto", 8'h01, {7'h00, o_sawtooth_auto});
		// Read valid is a one-cycle pulse
		@(negedge i_core_clk);
		chk("rvalid", 8'h00, {7'h00, o_reg_rvalid});
	endtask : t_restrap

	initial begin
		i_reset = 1'b1;
		{i_reg_write, i_reg_read, i_reg_addr, i_reg_wdata} = '0;
		i_own_addr_strap = 7'h52;
		i_peer_addr_strap = 7'h2B;
		i_config_strap_pins = 2'h0;
		repeat (2) @(negedge i_core_clk);
		i_reset = 1'b0;
		// Straps settle before the first write is honoured
		repeat (4) @(negedge i_core_clk);
		t_reset();
		t_spread();
		t_cal();
		t_lock();
		t_restrap();
		results();
	end

	initial begin
		repeat (2000) @(posedge i_core_clk);
		err_total++;
		results();
	end
endmodule : lscr_regs_test
